// ==== rtl/erc_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Standalone: select bit picks 5.0V or 3.3V
// - Voltage select ignored under load sharing
// - Enable bit in Normal locks standalone
// - First load-share write locks load sharing
// - Locked configuration never changes afterward
// - Soft reset keeps the lock
// - Standalone toggles on/off, no error flag
// - Load-share change attempt sets error flag
// - Standalone overcurrent limits, sets clearable flag
// - Standalone output undervoltage sets flag
// - Load sharing has no undervoltage flag
// - Load sharing never limits or flags overcurrent
// - Battery undervoltage switches off unless kept
// - Stop disables load sharing, Normal restores
// - Stop-keep holds load sharing in Stop
// - Fail-Safe shuts load sharing regulator down
// - Per-mode on/off table by configuration
// - Stop: high stage follows base current hysteresis
// - Normal: high-power stage only
module erc_ctrl (
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,          // Power-on reset
	input  wire logic       soft_reset_i,     // Device soft reset
	input  wire erc_pkg::erc_mode_t mode_i,   // Registered mode
	input  wire logic       wr_strobe_i,      // Control write pulse
	input  wire logic       standalone_enable_bit_i,
	input  wire logic       load_share_bit_i,
	input  wire logic       ext_reg_voltage_select_i,
	input  wire logic       stop_keep_bit_i,
	input  wire logic       keep_on_in_undervoltage_bit_i,
	input  wire logic       oc_clear_i,       // Clear overcurrent flag
	input  wire logic       uv_clear_i,       // Clear undervoltage flag
	input  wire logic       shunt_sense_pin_i, // Shunt threshold reached
	input  wire logic       output_sense_pin_i, // Output low
	input  wire logic       batt_uv_i,        // Battery undervoltage
	input  wire logic       base_hi_i,
	input  wire logic       base_lo_i,
	input  wire logic       main_reg_on_i,    // Main regulator state
	output logic            pass_base_drive_pin_o,
	output logic            current_limit_o,
	output logic            volt_3v3_o,
	output logic            hp_stage_o,
	output logic            lp_stage_o,
	output logic            overcurrent_flag_o,
	output logic            output_undervoltage_flag_o,
	output logic            spi_fail_o,
	output var erc_pkg::erc_cfg_t cfg_o
);

	// Pin synchronisers
	logic [1:0] sh_sync_ff;  // Shunt comparator
	logic [1:0] os_sync_ff;  // Output undervoltage comparator
	logic [1:0] uv_sync_ff;  // Battery undervoltage
	logic [1:0] bh_sync_ff;  // Base current above rising
	logic [1:0] bl_sync_ff;  // Base current below falling

	// Configuration and state
	erc_pkg::erc_cfg_t cfg_ff; // Locked configuration
	logic sw_on_ff;            // Software on/off in standalone
	logic hold_ff;             // State held in Stop, Sleep and Restart; cleared in Init and Fail-Safe
	logic run;                 // Combined enable decision
	logic nxt_run;
	logic sa;                  // Standalone in force
	logic ls;                  // Load sharing in force
	logic oc_ev;               // Overcurrent event
	logic uv_ev;               // Output undervoltage event
	logic cfg_try;             // Attempt to change configuration
	logic is_stop;

	erc_stage_if stg ();

	// Two flip-flops on every asynchronous comparator input
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			sh_sync_ff <= 2'h0;
			os_sync_ff <= 2'h0;
			uv_sync_ff <= 2'h0;
			bh_sync_ff <= 2'h0;
			bl_sync_ff <= 2'h0;
		end else begin
			sh_sync_ff <= {sh_sync_ff[0], shunt_sense_pin_i};
			os_sync_ff <= {os_sync_ff[0], output_sense_pin_i};
			uv_sync_ff <= {uv_sync_ff[0], batt_uv_i};
			bh_sync_ff <= {bh_sync_ff[0], base_hi_i};
			bl_sync_ff <= {bl_sync_ff[0], base_lo_i};
		end
	end

	assign sa = (cfg_ff == erc_pkg::ERC_CFG_STANDALONE);
	assign ls = (cfg_ff == erc_pkg::ERC_CFG_LOADSHARE);
	assign is_stop = (mode_i == erc_pkg::ERC_MODE_STOP);

	// Trying to switch configuration after the lock
	assign cfg_try = wr_strobe_i &&
		((sa && load_share_bit_i) ||
		 (ls && (standalone_enable_bit_i || !load_share_bit_i)));

	// Configuration lock; only power-on reset releases it
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cfg_ff <= erc_pkg::ERC_CFG_NONE;
		end else if (wr_strobe_i && cfg_ff == erc_pkg::ERC_CFG_NONE) begin
			if (load_share_bit_i) begin
				cfg_ff <= erc_pkg::ERC_CFG_LOADSHARE;
			end else if (standalone_enable_bit_i &&
			             mode_i == erc_pkg::ERC_MODE_NORMAL) begin
				cfg_ff <= erc_pkg::ERC_CFG_STANDALONE;
			end
		end
		// Soft reset does not touch cfg_ff
		// No other path writes cfg_ff
	end

	// Software on/off for standalone, writable in Normal only
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || soft_reset_i) begin
			sw_on_ff <= erc_pkg::ERC_OFF;
		end else if (wr_strobe_i && mode_i == erc_pkg::ERC_MODE_NORMAL &&
		             !load_share_bit_i && (sa ||
		             cfg_ff == erc_pkg::ERC_CFG_NONE)) begin
			sw_on_ff <= standalone_enable_bit_i;
		end
	end

	// Voltage select; ignored under load sharing
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || soft_reset_i) begin
			volt_3v3_o <= erc_pkg::ERC_VSEL_5V0;
		end else if (ls) begin
			volt_3v3_o <= erc_pkg::ERC_VSEL_5V0;
		end else if (wr_strobe_i) begin
			volt_3v3_o <= ext_reg_voltage_select_i;
		end
	end

	// Error flag: only under load sharing lock; set wins over clear
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || soft_reset_i) begin
			spi_fail_o <= 1'b0;
		end else if (cfg_try && ls) begin
			spi_fail_o <= 1'b1;
		end else if (wr_strobe_i) begin
			spi_fail_o <= 1'b0;
		end
	end

	// Per-mode enable decision, combinational; registered into the drive pin
	always_comb begin
		nxt_run = 1'b0;
		unique case (mode_i)
			erc_pkg::ERC_MODE_INIT:     nxt_run = 1'b0;
			erc_pkg::ERC_MODE_FAILSAFE: nxt_run = 1'b0;
			erc_pkg::ERC_MODE_NORMAL: begin
				nxt_run = ls || (sa && sw_on_ff);
			end
			erc_pkg::ERC_MODE_STOP: begin
				nxt_run = ls ? stop_keep_bit_i : hold_ff;
			end
			erc_pkg::ERC_MODE_SLEEP: begin
				nxt_run = ls ? 1'b0 : hold_ff;
			end
			erc_pkg::ERC_MODE_RESTART: begin
				nxt_run = ls ? main_reg_on_i : hold_ff;
			end
			default: nxt_run = 1'b0;
		endcase
		// Battery undervoltage gate
		if (uv_sync_ff[1] && !keep_on_in_undervoltage_bit_i) begin
			nxt_run = 1'b0;
		end
	end

	// Standalone state frozen in Stop, Sleep and Restart; cleared in Init and Fail-Safe
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			hold_ff <= erc_pkg::ERC_OFF;
		end else if (mode_i == erc_pkg::ERC_MODE_NORMAL) begin
			hold_ff <= sa && sw_on_ff;
		end else if (mode_i == erc_pkg::ERC_MODE_INIT ||
		             mode_i == erc_pkg::ERC_MODE_FAILSAFE) begin
			hold_ff <= erc_pkg::ERC_OFF;
		end
	end

	assign run = nxt_run;

	// Registered drive enable
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pass_base_drive_pin_o <= erc_pkg::ERC_OFF;
		end else begin
			pass_base_drive_pin_o <= run;
		end
	end

	assign oc_ev = sa && pass_base_drive_pin_o && sh_sync_ff[1];
	assign uv_ev = sa && pass_base_drive_pin_o && os_sync_ff[1];

	// Current limiting in standalone only
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			current_limit_o <= 1'b0;
		end else begin
			current_limit_o <= oc_ev;
		end
	end

	// Overcurrent flag; clear only once condition gone
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || soft_reset_i) begin
			overcurrent_flag_o <= 1'b0;
		end else if (oc_ev) begin
			overcurrent_flag_o <= 1'b1;
		end else if (oc_clear_i) begin
			overcurrent_flag_o <= 1'b0;
		end
	end

	// Output undervoltage flag, standalone only
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || soft_reset_i) begin
			output_undervoltage_flag_o <= 1'b0;
		end else if (uv_ev) begin
			output_undervoltage_flag_o <= 1'b1;
		end else if (uv_clear_i) begin
			output_undervoltage_flag_o <= 1'b0;
		end
	end

	// Stage selector inputs
	assign stg.run = run;
	assign stg.stop_md = is_stop;

	erc_stage_sel u_stage (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.base_hi_i (bh_sync_ff[1]),
		.base_lo_i (bl_sync_ff[1]),
		.stg       (stg)
	);

	// Registered stage outputs and configuration
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			hp_stage_o <= 1'b0;
			lp_stage_o <= 1'b0;
			cfg_o      <= erc_pkg::ERC_CFG_NONE;
		end else begin
			hp_stage_o <= stg.hp_on;
			lp_stage_o <= stg.lp_on;
			cfg_o      <= cfg_ff;
		end
	end

	// Assertions
	property p_lock_kept;
		@(posedge sys_clk_i) disable iff (reset_i)
		(cfg_ff != erc_pkg::ERC_CFG_NONE) |=> $stable(cfg_ff);
	endproperty
	a_lock_kept: assert property (p_lock_kept)
		else $error("locked configuration changed");

	property p_ls_fail;
		@(posedge sys_clk_i) disable iff (reset_i || soft_reset_i)
		(ls && cfg_try) |=> spi_fail_o;
	endproperty
	a_ls_fail: assert property (p_ls_fail)
		else $error("error flag not set on locked change");

	property p_sa_nofail;
		@(posedge sys_clk_i) disable iff (reset_i)
		(sa && wr_strobe_i) |=> !spi_fail_o;
	endproperty
	a_sa_nofail: assert property (p_sa_nofail)
		else $error("error flag set in standalone");

	// Watches the outputs, so a broken event gate shows up here
	property p_ls_no_oc;
		@(posedge sys_clk_i) disable iff (reset_i)
		ls |-> !current_limit_o && !overcurrent_flag_o &&
			!output_undervoltage_flag_o;
	endproperty
	a_ls_no_oc: assert property (p_ls_no_oc)
		else $error("limit or flag under load sharing");

	// Select bit has no effect once load sharing holds
	property p_ls_vsel;
		@(posedge sys_clk_i) disable iff (reset_i || soft_reset_i)
		ls |=> (volt_3v3_o == erc_pkg::ERC_VSEL_5V0);
	endproperty
	a_ls_vsel: assert property (p_ls_vsel)
		else $error("voltage select followed under load sharing");

	property p_failsafe_off;
		@(posedge sys_clk_i) disable iff (reset_i)
		(mode_i == erc_pkg::ERC_MODE_FAILSAFE) |=> !pass_base_drive_pin_o;
	endproperty
	a_failsafe_off: assert property (p_failsafe_off)
		else $error("regulator on in fail-safe");

	property p_batt_uv;
		@(posedge sys_clk_i) disable iff (reset_i)
		(uv_sync_ff[1] && !keep_on_in_undervoltage_bit_i)
			|=> !pass_base_drive_pin_o;
	endproperty
	a_batt_uv: assert property (p_batt_uv)
		else $error("regulator on in battery undervoltage");

	property p_stop_ls;
		@(posedge sys_clk_i) disable iff (reset_i)
		(ls && is_stop && !stop_keep_bit_i) |=> !pass_base_drive_pin_o;
	endproperty
	a_stop_ls: assert property (p_stop_ls)
		else $error("load sharing active in stop");

	property p_oc_flag;
		@(posedge sys_clk_i) disable iff (reset_i || soft_reset_i)
		oc_ev |=> overcurrent_flag_o;
	endproperty
	a_oc_flag: assert property (p_oc_flag)
		else $error("overcurrent flag missed");

	c_sa_lock: cover property (@(posedge sys_clk_i) $rose(sa));
	c_ls_lock: cover property (@(posedge sys_clk_i) $rose(ls));
	c_hp_stop: cover property (@(posedge sys_clk_i) is_stop && hp_stage_o);

endmodule

`default_nettype wire

// ==== rtl/erc_pkg.sv ====
package erc_pkg;

	// Operating modes supplied by the device mode state machine
	typedef enum logic [2:0] {
		ERC_MODE_INIT,
		ERC_MODE_NORMAL,
		ERC_MODE_STOP,
		ERC_MODE_SLEEP,
		ERC_MODE_RESTART,
		ERC_MODE_FAILSAFE
	} erc_mode_t;

	// Locked configuration of the auxiliary regulator
	typedef enum logic [1:0] {
		ERC_CFG_NONE,
		ERC_CFG_STANDALONE,
		ERC_CFG_LOADSHARE
	} erc_cfg_t;

	// Output voltage codes
	localparam logic ERC_VSEL_5V0 = 1'b0;
	localparam logic ERC_VSEL_3V3 = 1'b1;

	// Reset values
	localparam logic ERC_OFF = 1'b0;

endpackage

// ==== rtl/erc_stage_if.sv ====
`timescale 1ns/1ns
`default_nettype none

// Stage selection handshake between the control core and stage selector
interface erc_stage_if;
	logic run;     // Regulator enabled
	logic stop_md; // Stop mode in force
	logic hp_on;   // High-power stage on
	logic lp_on;   // Low-power stage on

	modport ctrl (output run, output stop_md, input hp_on, input lp_on);
	modport sel  (input run, input stop_md, output hp_on, output lp_on);
endinterface

`default_nettype wire

// ==== rtl/erc_stage_sel.sv ====
`timescale 1ns/1ns
`default_nettype none

// Chooses between low-power and high-power regulator stages
module erc_stage_sel (
	input  wire logic   sys_clk_i,
	input  wire logic   reset_i,
	input  wire logic   base_hi_i, // Base current above rising threshold
	input  wire logic   base_lo_i, // Base current below falling threshold
	erc_stage_if.sel    stg
);

	logic hp_ff; // High-power stage in Stop mode
	logic nxt_hp;

	// Hysteresis between rising and falling base current thresholds
	always_comb begin
		nxt_hp = hp_ff;
		if (!stg.run || !stg.stop_md) begin
			nxt_hp = 1'b0;
		end else if (base_hi_i) begin
			nxt_hp = 1'b1;
		end else if (base_lo_i) begin
			nxt_hp = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			hp_ff <= 1'b0;
		end else begin
			hp_ff <= nxt_hp;
		end
	end

	// Normal mode runs only the high-power stage
	assign stg.hp_on = stg.run && (!stg.stop_md || hp_ff);
	assign stg.lp_on = stg.run && stg.stop_md;

endmodule

`default_nettype wire

// ==== dv/erc_pnp_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// Behavioural pass transistor, shunt resistor and output load
module erc_pnp_model (
	input  wire logic       drive_i,   // Base drive enable from block
	input  wire logic [1:0] load_i,    // 0 idle, 1 mid, 2 heavy, 3 over
	input  wire logic       short_i,   // Load fault pulling output low
	output logic            shunt_o,   // Shunt drop at threshold
	output logic            low_o,     // Output below its limit
	output logic            base_hi_o, // Base current above rising point
	output logic            base_lo_o  // Base current below falling point
);
	// Threshold only reached while current flows
	assign shunt_o = drive_i & (load_i == 2'h3);
	// Output sags only while driven into a fault
	assign low_o = drive_i & short_i;
	// Mid load sits inside the hysteresis band
	assign base_hi_o = drive_i & load_i[1];
	// No drive means no base current
	assign base_lo_o = !drive_i | (load_i == 2'h0);
endmodule

`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none

module testbench;
	// One row of the load-sharing mode table
	typedef struct {
		erc_pkg::erc_mode_t m;    // Mode applied
		logic               keep; // Stop-keep bit
		logic               mreg; // Main regulator state
		logic               drv;  // Expected base drive
	} erc_row_t;

	erc_pkg::erc_mode_t mode;                     // Mode fed to the block
	erc_pkg::erc_cfg_t  cfg;                      // Locked configuration
	logic               clk, rst, srst, wr;       // Clock, resets, strobe
	logic               en, ls, vs, keep, kuv;    // Control bits
	logic               occ, uvc, batt, mreg;     // Clears and supplies
	logic               shunt, olow, bhi, blo;    // Partner sense lines
	logic               shrt;                     // Output fault request
	logic [1:0]         load;                     // Load level request
	logic               drv, lim, v33, hp, lp;    // Regulator outputs
	logic               ocf, uvf, spi;            // Flags
	int                 miscompares, cmp_count;   // Tallies
	erc_row_t           rows [10] = '{
		'{erc_pkg::ERC_MODE_NORMAL,   0, 0, 1},
		'{erc_pkg::ERC_MODE_STOP,     0, 0, 0},
		'{erc_pkg::ERC_MODE_NORMAL,   0, 0, 1},
		'{erc_pkg::ERC_MODE_STOP,     1, 0, 1},
		'{erc_pkg::ERC_MODE_SLEEP,    0, 1, 0},
		'{erc_pkg::ERC_MODE_RESTART,  0, 1, 1},
		'{erc_pkg::ERC_MODE_RESTART,  0, 0, 0},
		'{erc_pkg::ERC_MODE_FAILSAFE, 0, 1, 0},
		'{erc_pkg::ERC_MODE_INIT,     0, 1, 0},
		'{erc_pkg::ERC_MODE_NORMAL,   0, 0, 1}
	};

	// Block under test
	erc_ctrl erc_ctrl_i (
		.sys_clk_i(clk), .reset_i(rst), .soft_reset_i(srst),
		.mode_i(mode), .wr_strobe_i(wr), .standalone_enable_bit_i(en),
		.load_share_bit_i(ls), .ext_reg_voltage_select_i(vs),
		.stop_keep_bit_i(keep), .keep_on_in_undervoltage_bit_i(kuv),
		.oc_clear_i(occ), .uv_clear_i(uvc), .shunt_sense_pin_i(shunt),
		.output_sense_pin_i(olow), .batt_uv_i(batt), .base_hi_i(bhi),
		.base_lo_i(blo), .main_reg_on_i(mreg),
		.pass_base_drive_pin_o(drv), .current_limit_o(lim),
		.volt_3v3_o(v33), .hp_stage_o(hp), .lp_stage_o(lp),
		.overcurrent_flag_o(ocf), .output_undervoltage_flag_o(uvf),
		.spi_fail_o(spi), .cfg_o(cfg)
	);

	// Far side of the base drive
	erc_pnp_model erc_pnp_model_i (
		.drive_i(drv), .load_i(load), .short_i(shrt), .shunt_o(shunt),
		.low_o(olow), .base_hi_o(bhi), .base_lo_o(blo)
	);

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Compare and tally
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Covers sync stages, flag register and drive register
	task automatic settle;
		repeat (6) @(negedge clk);
	endtask

	// One control write
	task automatic write(input logic e, input logic l, input logic v);
		@(negedge clk);
		{wr, en, ls, vs} = {1'b1, e, l, v};
		@(negedge clk);
		wr = 1'b0;
		settle();
	endtask

	// Clear pulse for the flags
	task automatic clear_flags;
		@(negedge clk);
		{occ, uvc} = 2'h3;
		@(negedge clk);
		{occ, uvc} = 2'h0;
		settle();
	endtask

	// Supply removal and return
	task automatic power_up;
		rst = 1'b1;
		repeat (12) @(negedge clk);
		rst = 1'b0;
	endtask

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Hang guard
	initial begin
		#1000000;
		miscompares++;
		give_verdict();
	end

	// Main sequence
	initial begin
		{srst, wr, en, ls, vs, keep, kuv, occ, uvc, batt, mreg} = '0;
		{shrt, load, rst} = 4'h1;
		mode = erc_pkg::ERC_MODE_INIT;
		miscompares = 0;
		cmp_count = 0;
		power_up();
		chk(cfg, erc_pkg::ERC_CFG_NONE);
		chk(drv, 1'b0);
		// Lock load sharing right after power-up, then try to leave it
		mode = erc_pkg::ERC_MODE_NORMAL;
		write(1'b0, 1'b1, 1'b1);
		chk(cfg, erc_pkg::ERC_CFG_LOADSHARE);
		chk(v33, 1'b0);
		write(1'b0, 1'b0, 1'b0);
		chk(spi, 1'b1);
		chk(cfg, erc_pkg::ERC_CFG_LOADSHARE);
		// Table of modes
		foreach (rows[i]) begin
			mode = rows[i].m;
			keep = rows[i].keep;
			mreg = rows[i].mreg;
			settle();
			chk(drv, rows[i].drv);
		end
		$display("test load share modes done");
		// No limiting and no flags while sharing
		{keep, load, shrt} = 4'h7;
		settle();
		chk({lim, ocf}, 8'h00);
		chk(uvf, 1'b0);
		{load, shrt, batt} = 4'h1;
		settle();
		chk(drv, 1'b0);
		batt = 1'b0;
		settle();
		chk(drv, 1'b1);
		$display("test load share faults done");
		// Standalone needs Normal mode
		power_up();
		mode = erc_pkg::ERC_MODE_INIT;
		write(1'b1, 1'b0, 1'b1);
		chk(cfg, erc_pkg::ERC_CFG_NONE);
		mode = erc_pkg::ERC_MODE_NORMAL;
		write(1'b1, 1'b0, 1'b1);
		chk(cfg, erc_pkg::ERC_CFG_STANDALONE);
		chk({drv, v33}, 8'h03);
		chk({hp, lp}, 8'h02);
		write(1'b1, 1'b0, 1'b0);
		chk(v33, 1'b0);
		write(1'b1, 1'b1, 1'b0);
		chk(cfg, erc_pkg::ERC_CFG_STANDALONE);
		chk(spi, 1'b0);
		// Overcurrent flag survives a clear while the event lasts
		load = 2'h3;
		settle();
		chk({lim, ocf}, 8'h03);
		clear_flags();
		chk(ocf, 1'b1);
		load = 2'h0;
		settle();
		clear_flags();
		chk(ocf, 1'b0);
		// Output undervoltage; let the fault drain through the sync first
		shrt = 1'b1;
		settle();
		chk(uvf, 1'b1);
		shrt = 1'b0;
		settle();
		clear_flags();
		chk(uvf, 1'b0);
		// Battery undervoltage with and without the keep bit
		{kuv, batt} = 2'h3;
		settle();
		chk(drv, 1'b1);
		kuv = 1'b0;
		settle();
		chk(drv, 1'b0);
		batt = 1'b0;
		settle();
		chk(drv, 1'b1);
		$display("test standalone normal done");
		// Stop mode holds state, stages follow base current
		mode = erc_pkg::ERC_MODE_STOP;
		settle();
		chk({drv, hp, lp}, 8'h05);
		load = 2'h2;
		settle();
		chk(hp, 1'b1);
		load = 2'h1;
		settle();
		chk(hp, 1'b1);
		load = 2'h0;
		settle();
		chk(hp, 1'b0);
		mode = erc_pkg::ERC_MODE_SLEEP;
		settle();
		chk(drv, 1'b1);
		mode = erc_pkg::ERC_MODE_RESTART;
		settle();
		chk(drv, 1'b1);
		mode = erc_pkg::ERC_MODE_FAILSAFE;
		settle();
		chk(drv, 1'b0);
		// Switch off, then soft reset keeps the lock
		mode = erc_pkg::ERC_MODE_NORMAL;
		write(1'b0, 1'b0, 1'b0);
		chk({drv, spi}, 8'h00);
		@(negedge clk);
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		settle();
		chk(cfg, erc_pkg::ERC_CFG_STANDALONE);
		$display("test standalone modes done");
		give_verdict();
	end
endmodule

`default_nettype wire
